//--- spre_engine.sv
// SPI mode 3 slave giving access to a 320-byte configuration map.
// Assumes SCK, CS and SDI are asynchronous and SCK is far slower than aclk.
`default_nettype none
module spre_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe
);
	import spre_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, third stage only for edge detection
	logic [2:0] sck_s;
	logic [2:0] cs_s;
	logic [1:0] sdi_s;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_s <= 3'h7;
			cs_s <= 3'h7;
			sdi_s <= 2'h0;
		end else begin
			sck_s <= {sck_s[1:0], sck};
			cs_s <= {cs_s[1:0], cs_n};
			sdi_s <= {sdi_s[0], sdi};
		end
	end
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];
	wire cs_act = ~cs_s[1];
	wire cs_rise = cs_s[1] & ~cs_s[2];
	assign sdo_oe = cs_act;

	////////////////////////////////////////////////////////////////////////////
	// State
	spre_ctrl_t ctrl;
	spre_state_t state;
	logic mb_err, crc_err;
	logic [3:0] bit_cnt;
	logic [15:0] shreg;
	logic is_read, multi, byte_idx;
	logic [14:0] start_addr, cur_addr, tr_addr;
	logic [3:0] loop_n;
	logic [7:0] crc, tx;
	logic [7:0] stage [2];
	logic commit_req, cm_multi;
	logic [14:0] cm_addr;
	logic [7:0] mem [MAP_BYTES];

	// Next byte address with map wraparound
	function automatic logic [14:0] step(input logic [14:0] a, input logic up);
		if (up)
			step = (a >= MAP_TOP) ? 15'h0000 : a + 15'h0001;
		else
			step = (a == 15'h0000) ? MAP_TOP : a - 15'h0001;
	endfunction : step

	// One checksum bit, MSB first
	function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
		crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
	endfunction : crc_bit

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode and transaction set-up
	wire [15:0] iword = {shreg[14:0], sdi_s[1]};
	wire [7:0] rx_byte = iword[7:0];
	wire asel = ctrl.address_length_select;
	wire [14:0] dec_addr = asel ? {8'h00, iword[6:0]} : iword[14:0];
	wire dec_read = asel ? iword[7] : iword[15];
	wire [3:0] instr_last = asel ? INSTR_LAST_SHORT : INSTR_LAST_LONG;
	wire [14:0] nxt_cur = step(cur_addr, ctrl.addr_dir);
	wire loop_hit = (ctrl.loop_count != 4'h0) && (loop_n + 4'h1 == ctrl.loop_count);
	wire in_instr = state == ST_INSTR;
	wire [14:0] tb_addr = in_instr ? dec_addr : (loop_hit ? start_addr : nxt_cur);
	wire tb_multi = ctrl.multibyte_atomic_enable && tb_addr >= MB_LO && tb_addr <= MB_HI;
	wire [14:0] tb_base = tb_multi ? {tb_addr[14:1], 1'b0} : tb_addr;
	wire [14:0] tb_first = (tb_multi && !ctrl.addr_dir) ? {tb_addr[14:1], 1'b1} : tb_base;
	wire [7:0] rd_first = (tb_first <= MAP_TOP) ? mem[tb_first[8:0]] : 8'h00;
	wire [7:0] rd_next = (nxt_cur <= MAP_TOP) ? mem[nxt_cur[8:0]] : 8'h00;

	// Byte and transaction boundaries
	wire rx_end = sck_rise && bit_cnt[2:0] == 3'h7;
	wire last_byte = !multi || byte_idx;
	wire [7:0] crc_nxt = crc_bit(crc, is_read ? sdo : sdi_s[1]);
	wire data_last = state == ST_DATA && rx_end && last_byte;
	wire crc_end = state == ST_CRC && rx_end;
	wire txn_end = (data_last && !ctrl.crc_en) || crc_end;
	wire crc_bad = crc_end && !is_read && rx_byte != crc;
	wire wr_ok = !is_read && ((data_last && !ctrl.crc_en) || (crc_end && rx_byte == crc));
	wire instr_done = in_instr && sck_rise && bit_cnt == instr_last;
	wire streaming = !ctrl.instruction_mode_select;
	wire start_tx = instr_done || (txn_end && streaming && !crc_bad);
	wire mb_short = cs_rise && state == ST_DATA && multi && (byte_idx || bit_cnt != 4'h0);

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 16'h0000;
			is_read <= 1'b0;
			start_addr <= 15'h0000;
			cur_addr <= 15'h0000;
			tr_addr <= 15'h0000;
			multi <= 1'b0;
			byte_idx <= 1'b0;
			loop_n <= 4'h0;
			crc <= CRC_SEED;
			tx <= 8'h00;
			sdo <= 1'b0;
		end else if (!cs_act) begin
			state <= ST_IDLE;
		end else if (state == ST_IDLE) begin
			state <= ST_INSTR;
			bit_cnt <= 4'h0;
			loop_n <= 4'h0;
		end else if (sck_rise && state != ST_DEAD) begin
			shreg <= iword;
			bit_cnt <= bit_cnt + 4'h1;
			if (state == ST_DATA)
				crc <= crc_nxt;
			if (instr_done) begin
				is_read <= dec_read;
				start_addr <= dec_addr;
			end
			if (txn_end)
				loop_n <= (loop_hit || !streaming) ? 4'h0 : loop_n + 4'h1;
			if (start_tx) begin
				state <= ST_DATA;
				cur_addr <= tb_first;
				tr_addr <= tb_base;
				multi <= tb_multi;
				byte_idx <= 1'b0;
				bit_cnt <= 4'h0;
				crc <= CRC_SEED;
				tx <= rd_first;
			end else if (txn_end) begin
				// Only a stream goes deaf after a bad checksum; single mode takes a new instruction
				state <= (crc_bad && streaming) ? ST_DEAD : ST_INSTR;
				bit_cnt <= 4'h0;
			end else if (data_last) begin
				state <= ST_CRC;
				bit_cnt <= 4'h0;
				tx <= crc_nxt;
			end else if (state == ST_DATA && rx_end) begin
				byte_idx <= 1'b1;
				cur_addr <= nxt_cur;
				tx <= rd_next;
				bit_cnt <= 4'h0;
			end
		end else if (sck_fall) begin
			sdo <= tx[7];
			tx <= {tx[6:0], 1'b0};
		end
	end

	// Write byte staging, captured on rising edges
	always_ff @(posedge aclk) begin
		if (state == ST_DATA && rx_end && !is_read)
			stage[multi ? cur_addr[0] : 1'b0] <= rx_byte;
	end

	// Commit strobe one cycle after the deciding edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			commit_req <= 1'b0;
			cm_multi <= 1'b0;
			cm_addr <= 15'h0000;
		end else begin
			commit_req <= wr_ok;
			if (wr_ok) begin
				cm_multi <= multi;
				cm_addr <= tr_addr;
			end
		end
	end

	// Register map storage, multibyte registers written together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < MAP_BYTES; i++)
				mem[i] <= 8'h00;
		end else if (commit_req && cm_addr <= MAP_TOP) begin
			mem[cm_addr[8:0]] <= stage[0];
			if (cm_multi)
				mem[cm_addr[8:0] + 9'h001] <= stage[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data taken together
	wire aw_take = awvalid && wvalid && !bvalid;
	wire ar_take = arvalid && !rvalid;
	assign awready = aw_take;
	assign wready = aw_take;
	assign arready = ar_take;
	wire w_ctrl = awaddr == OFS_CTRL;
	wire w_stat = awaddr == OFS_STAT;
	wire [11:0] ctrl_m = {{4{wstrb[1]}}, 3'b000, {5{wstrb[0]}}};
	wire [1:0] w1c = (aw_take && w_stat && wstrb[0]) ? wdata[1:0] : 2'b00;
	spre_stat_t stat_v;
	assign stat_v = '{frame_active: cs_act, checksum_error_flag: crc_err,
		multibyte_error_flag: mb_err};

	// Control register and sticky flags, a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
			mb_err <= 1'b0;
			crc_err <= 1'b0;
		end else begin
			if (aw_take && w_ctrl)
				ctrl <= spre_ctrl_t'((ctrl & ~ctrl_m) | (wdata[11:0] & ctrl_m & 12'hf1f));
			mb_err <= (mb_err & ~w1c[0]) | mb_short;
			crc_err <= (crc_err & ~w1c[1]) | crc_bad;
		end
	end

	// Write response and read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			if (aw_take) begin
				bvalid <= 1'b1;
				bresp <= (w_ctrl || w_stat) ? RESP_OKAY : RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
			if (ar_take) begin
				rvalid <= 1'b1;
				rresp <= (araddr == OFS_CTRL || araddr == OFS_STAT) ? RESP_OKAY : RESP_SLVERR;
				rdata <= (araddr == OFS_CTRL) ? {20'h00000, ctrl} :
					(araddr == OFS_STAT) ? {29'h0000_0000, stat_v} : 32'h0000_0000;
			end else if (rready)
				rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_last_wbyte;
		state == ST_DATA && !is_read && last_byte && rx_end;
	endsequence

	chk_ctrl_reset: assert property ($rose(aresetn) |-> ctrl == CTRL_RST)
		else $error("control word not at reset value");
	chk_commit_nocrc: assert property (s_last_wbyte ##0 !ctrl.crc_en |=> commit_req)
		else $error("write not committed after last data edge");
	chk_commit_wait: assert property (s_last_wbyte ##0 ctrl.crc_en |=> !commit_req [*2])
		else $error("write committed before checksum");
	chk_crc_reject: assert property (crc_bad |=> !commit_req && crc_err)
		else $error("bad checksum not rejected");
	chk_mb_short: assert property (mb_short |=> mb_err && !commit_req)
		else $error("short multibyte access not flagged");
	chk_stream_wrap: assert property (txn_end && streaming && !crc_bad && !loop_hit
		&& !ctrl.multibyte_atomic_enable && !ctrl.addr_dir && cur_addr == 15'h0000
		|=> cur_addr == MAP_TOP)
		else $error("descending stream did not wrap");
	chk_loop_reload: assert property (txn_end && streaming && !crc_bad && loop_hit
		&& !ctrl.multibyte_atomic_enable |=> cur_addr == $past(start_addr))
		else $error("loop did not reload start address");
	chk_single_instr: assert property (txn_end && !streaming |=> state == ST_INSTR)
		else $error("no new instruction phase in single mode");
	chk_sdo_shift: assert property (sck_fall && state == ST_DATA && cs_act
		|=> sdo == $past(tx[7]))
		else $error("sdo not shifted on falling edge");

	// Frame cut by chip select while a data phase is open
	sequence s_cut_frame;
		cs_rise && state == ST_DATA;
	endsequence

	// Stream ignores the rest of the frame after a bad checksum
	chk_stream_dead: assert property (crc_bad && streaming && cs_act
		|=> state == ST_DEAD)
		else $error("stream not halted after bad checksum");
	// Byte order of an atomic pair
	chk_desc_msb: assert property (start_tx && tb_multi && !ctrl.addr_dir && cs_act
		|=> cur_addr[0])
		else $error("descending pair did not start at the high byte");
	chk_asc_lsb: assert property (start_tx && tb_multi && ctrl.addr_dir && cs_act
		|=> !cur_addr[0])
		else $error("ascending pair did not start at the low byte");
	// Partial byte never reaches the map
	chk_partial_drop: assert property (s_cut_frame ##0 !multi && !sck_rise
		|=> !commit_req)
		else $error("partial byte committed");
	chk_dir_fixed: assert property (state == ST_DATA |=> is_read == $past(is_read))
		else $error("transfer direction changed inside a data phase");
	chk_loop_restart: assert property (txn_end && streaming && !crc_bad && loop_hit && cs_act
		|=> loop_n == 4'h0)
		else $error("loop counter not restarted");
	chk_crc_accept: assert property (crc_end && !is_read && rx_byte == crc |=> commit_req)
		else $error("matching checksum not committed");
	chk_pair_base: assert property (commit_req && cm_multi |-> !cm_addr[0])
		else $error("atomic pair not committed at its low byte");
endmodule : spre_engine
`default_nettype wire

//--- spre_pkg.sv
// Shared constants and types for the SPI register access engine.
// Assumes a single aclk domain; SPI pins are asynchronous to it.
`default_nettype none
package spre_pkg;
	// Register map extent and the window of two-byte registers
	localparam int MAP_BYTES = 320;
	localparam logic [14:0] MAP_TOP = 15'h013f;
	localparam logic [14:0] MB_LO = 15'h0040;
	localparam logic [14:0] MB_HI = 15'h005f;
	// Checksum polynomial and starting value
	localparam logic [7:0] CRC_SEED = 8'ha5;
	localparam logic [7:0] CRC_POLY = 8'h07;
	// Last instruction bit index, long and short addressing
	localparam logic [3:0] INSTR_LAST_LONG = 4'hf;
	localparam logic [3:0] INSTR_LAST_SHORT = 4'h7;
	// AXI4-Lite register offsets and answers
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Control word layout
	typedef struct packed {
		logic [3:0] loop_count;
		logic [2:0] rsvd;
		logic crc_en;
		logic address_length_select;
		logic instruction_mode_select;
		logic multibyte_atomic_enable;
		logic addr_dir;
	} spre_ctrl_t;
	localparam spre_ctrl_t CTRL_RST = 12'h002;
	// Status word layout
	typedef struct packed {
		logic frame_active;
		logic checksum_error_flag;
		logic multibyte_error_flag;
	} spre_stat_t;
	// Frame sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_INSTR = 5'b00010,
		ST_DATA = 5'b00100,
		ST_CRC = 5'b01000,
		ST_DEAD = 5'b10000
	} spre_state_t;
endpackage : spre_pkg
`default_nettype wire

//--- spre_host.sv
// Host SPI controller model, mode 3, one frame at a time.
// Assumes aclk runs; each SCK half lasts four aclk cycles.
`default_nettype none
module spre_host (
	input wire logic aclk,
	output logic cs_n,
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels at time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b1;
		sdi = 1'b0;
	end
	////////////////////////////////////////
	// Wait in aclk cycles
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask : wt
	// Shift nb bits MSB first; SCK stands high between bytes
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			sck <= 1'b0;
			sdi <= tx[i];
			wt(4);
			sck <= 1'b1;
			wt(1);
			rx[i] = sdo;
			wt(3);
		end
	endtask : xfer
	// Read/write bit, then long or short address
	task automatic instr(input logic rd, input logic [14:0] a, input logic sh);
		logic [7:0] r;
		if (sh) begin
			xfer({rd, a[6:0]}, 8, r);
		end else begin
			xfer({rd, a[14:8]}, 8, r);
			xfer(a[7:0], 8, r);
		end
	endtask : instr
	task automatic fbeg;
		cs_n <= 1'b0;
		wt(4);
	endtask : fbeg
	// Released sdi shows the inverse level
	task automatic fend;
		wt(4);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		wt(8);
	endtask : fend
endmodule : spre_host
`default_nettype wire

//--- tb_spi_register_access_engine.sv
// Self-checking bench: AXI4-Lite setup, SPI host traffic, map readback.
// Assumes spre_pkg, spre_engine and spre_host are compiled first.
`default_nettype none
module tb_spi_register_access_engine;
	timeunit 1ns;
	timeprecision 1ns;
	import spre_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [3:0] araddr = 4'h0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, cs_n, sck, sdi, sdo, sdo_oe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int num_errors = 0;
	int cmp_count = 0;
	// 20 MHz clock
	always #25 aclk = ~aclk;
	spre_engine i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .cs_n, .sck, .sdi, .sdo, .sdo_oe);
	spre_host i_host (.aclk, .cs_n, .sck, .sdi, .sdo);
	////////////////////////////////////////
	task automatic test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo(input int n);
		if (n >= 40) begin
			chk("timeout", 32'h1, 32'h0);
			test_done;
		end
	endtask : tmo
	// Write: address and data offered together, flags tested at negedge
	task automatic aw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do @(negedge aclk); while (awready !== 1'b1 && ++n < 40);
		tmo(n);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(negedge aclk); while (bvalid !== 1'b1 && ++n < 40);
		tmo(n);
		chk("bresp", {30'h0, bresp}, {30'h0, r});
		@(posedge aclk);
		bready <= 1'b0;
	endtask : aw
	task automatic ar(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do @(negedge aclk); while (arready !== 1'b1 && ++n < 40);
		tmo(n);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1 && ++n < 40);
		tmo(n);
		chk("rdata", rdata, d);
		chk("rresp", {30'h0, rresp}, {30'h0, r});
		@(posedge aclk);
		rready <= 1'b0;
	endtask : ar
	task automatic cfg(input logic [11:0] c);
		aw(OFS_CTRL, {20'h0, c}, RESP_OKAY);
	endtask : cfg
	// SPI frames: one instruction, then stream of bytes
	task automatic sw(input logic [14:0] a, input logic [7:0] d[$], input logic sh);
		logic [7:0] r;
		i_host.fbeg;
		i_host.instr(1'b0, a, sh);
		foreach (d[i]) i_host.xfer(d[i], 8, r);
		i_host.fend;
	endtask : sw
	task automatic sr(input logic [14:0] a, input logic [7:0] e[$]);
		logic [7:0] r;
		i_host.fbeg;
		i_host.instr(1'b1, a, 1'b0);
		foreach (e[i]) begin
			i_host.xfer(8'h00, 8, r);
			chk("spi_read", {24'h0, r}, {24'h0, e[i]});
		end
		i_host.fend;
	endtask : sr
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = CRC_SEED;
		for (int i = 7; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8
	////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] r;
		logic [7:0] c;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
		chk("sdo_oe", {31'h0, sdo_oe}, 32'h0);
		ar(OFS_CTRL, 32'h2, RESP_OKAY);
		ar(OFS_STAT, 32'h0, RESP_OKAY);
		ar(4'h8, 32'h0, RESP_SLVERR);
		aw(4'hc, 32'h1f, RESP_SLVERR);
		ar(OFS_CTRL, 32'h2, RESP_OKAY);
		cfg(12'h001);
		sw(15'h013e, '{8'h11, 8'h22, 8'h33}, 1'b0);
		sr(15'h013e, '{8'h11, 8'h22, 8'h33});
		cfg(12'h201);
		sr(15'h013e, '{8'h11, 8'h22, 8'h11, 8'h22});
		cfg(12'h008);
		sw(15'h0000, '{8'h77, 8'h88}, 1'b1);
		cfg(12'h000);
		sr(15'h0000, '{8'h77, 8'h88});
		cfg(12'h003);
		sw(15'h0040, '{8'ha1, 8'hb2}, 1'b0);
		sw(15'h0042, '{8'h99}, 1'b0);
		ar(OFS_STAT, 32'h1, RESP_OKAY);
		cfg(12'h002);
		sr(15'h0040, '{8'hb2, 8'ha1});
		cfg(12'h000);
		sr(15'h0043, '{8'h00, 8'h00});
		aw(OFS_STAT, 32'h1, RESP_OKAY);
		ar(OFS_STAT, 32'h0, RESP_OKAY);
		// Partial write byte cut by chip select
		cfg(12'h001);
		i_host.fbeg;
		@(negedge aclk);
		chk("sdo_oe_on", {31'h0, sdo_oe}, 32'h1);
		ar(OFS_STAT, 32'h4, RESP_OKAY);
		i_host.instr(1'b0, 15'h0010, 1'b0);
		i_host.xfer(8'hf0, 4, r);
		i_host.fend;
		sr(15'h0010, '{8'h00});
		// Write then read in one frame
		cfg(12'h005);
		i_host.fbeg;
		i_host.instr(1'b0, 15'h0100, 1'b0);
		i_host.xfer(8'h66, 8, r);
		i_host.instr(1'b1, 15'h0100, 1'b0);
		i_host.xfer(8'h00, 8, r);
		i_host.fend;
		chk("single", {24'h0, r}, 32'h66);
		// Good and bad checksums, then checked readback
		cfg(12'h015);
		i_host.fbeg;
		i_host.instr(1'b0, 15'h0101, 1'b0);
		i_host.xfer(8'h5a, 8, r);
		i_host.xfer(crc8(8'h5a), 8, r);
		i_host.instr(1'b0, 15'h0102, 1'b0);
		i_host.xfer(8'h3c, 8, r);
		i_host.xfer(~crc8(8'h3c), 8, r);
		i_host.instr(1'b1, 15'h0101, 1'b0);
		i_host.xfer(8'h00, 8, c);
		i_host.xfer(8'h00, 8, r);
		i_host.fend;
		chk("crc_data", {24'h0, c}, 32'h5a);
		chk("crc_sum", {24'h0, r}, {24'h0, crc8(8'h5a)});
		cfg(12'h000);
		sr(15'h0102, '{8'h00});
		ar(OFS_STAT, 32'h2, RESP_OKAY);
		// Bad checksum silences the rest of a stream
		aw(OFS_STAT, 32'h2, RESP_OKAY);
		ar(OFS_STAT, 32'h0, RESP_OKAY);
		cfg(12'h011);
		i_host.fbeg;
		i_host.instr(1'b0, 15'h0020, 1'b0);
		i_host.xfer(8'h44, 8, r);
		i_host.xfer(~crc8(8'h44), 8, r);
		i_host.xfer(8'h55, 8, r);
		i_host.xfer(crc8(8'h55), 8, r);
		i_host.fend;
		cfg(12'h000);
		sr(15'h0021, '{8'h00, 8'h00});
		ar(OFS_STAT, 32'h2, RESP_OKAY);
		test_done;
	end
endmodule : tb_spi_register_access_engine
`default_nettype wire
